/* File: atf_trigger_ctrl.v */
// Converter trigger selection, A/B ping-pong and conversion sequencing
`timescale 1ns/1ps
`default_nettype none
`include "atf_map.vh"
module atf_trigger_ctrl #(
   parameter [7:0] CONV_CYCLES = `ATF_CONV_CYCLES
) (
   input  wire                 clk_in,
   input  wire                 rst_b_in,
   input  wire                 trigger_source_select_in,
   input  wire                 hw_trigger_enable_in,
   input  wire                 continuous_in,
   input  wire [2:0]           power_mode_in,
   input  wire [1:0]           reference_select_in,
   input  wire                 timer_ch0_in,
   input  wire                 timer_ch1_in,
   input  wire                 tod_match_in,
   input  wire                 ctrl_a_wr_in,
   input  wire [`ATF_CH_W-1:0] ctrl_a_ch_in,
   input  wire                 ctrl_a_diff_in,
   input  wire                 ctrl_b_wr_in,
   input  wire [`ATF_CH_W-1:0] ctrl_b_ch_in,
   input  wire                 ctrl_b_diff_in,
   input  wire [1:0]           res_mode_in,
   input  wire                 result_a_lo_rd_in,
   input  wire                 result_b_lo_rd_in,
   input  wire [15:0]          sar_data_in,
   input  wire                 latch_a_clr_in,
   input  wire                 latch_b_clr_in,
   output reg                  busy_out,
   output reg                  sar_start_out,
   output reg  [`ATF_CH_W-1:0] sar_channel_out,
   output reg                  sar_diff_out,
   output reg  [1:0]           reference_out,
   output reg                  select_latch_a_out,
   output reg                  select_latch_b_out,
   output reg                  conversion_complete_a_out,
   output reg                  conversion_complete_b_out,
   output reg  [15:0]          result_a_out,
   output reg  [15:0]          result_b_out
);
   localparam ST_IDLE = 1'b0;
   localparam ST_CONV = 1'b1;

   // All-ones channel code blocks software starts and continuous repeats; hardware triggers still convert
   function chan_off;
      input [`ATF_CH_W-1:0] ch;
      begin
         chan_off = (ch == `ATF_CH_DISABLED);
      end
   endfunction

   wire ch0_rise;
   wire ch1_rise;
   wire tod_rise;
   wire [15:0] fmt_data;

   atf_edge_sync u_sync_ch0 (
      .clk_in    (clk_in),
      .rst_b_in  (rst_b_in),
      .d_in      (timer_ch0_in),
      .level_out (),
      .rise_out  (ch0_rise)
   );
   atf_edge_sync u_sync_ch1 (
      .clk_in    (clk_in),
      .rst_b_in  (rst_b_in),
      .d_in      (timer_ch1_in),
      .level_out (),
      .rise_out  (ch1_rise)
   );
   atf_edge_sync u_sync_tod (
      .clk_in    (clk_in),
      .rst_b_in  (rst_b_in),
      .d_in      (tod_match_in),
      .level_out (),
      .rise_out  (tod_rise)
   );

   reg                 state_reg;
   reg                 state_next;
   reg [7:0]           count_reg;
   reg [7:0]           count_next;
   reg                 use_b_reg;
   reg                 use_b_next;
   reg [`ATF_CH_W-1:0] ch_a_reg;
   reg                 diff_a_reg;
   reg [`ATF_CH_W-1:0] ch_b_reg;
   reg                 diff_b_reg;

   atf_result_fmt u_fmt (
      .raw_in     (sar_data_in),
      .diff_in    (sar_diff_out),
      .mode_in    (res_mode_in),
      .result_out (fmt_data)
   );

   // Trigger qualification
   wire in_stop   = (power_mode_in == `ATF_PMODE_STOP3);
   wire tmr_mode  = hw_trigger_enable_in & trigger_source_select_in;
   wire tod_mode  = hw_trigger_enable_in & ~trigger_source_select_in;
   // Timer path is dead in stop; match path still runs there
   wire trig_a    = tmr_mode & ~in_stop & ch0_rise;
   wire trig_b    = tmr_mode & ~in_stop & ch1_rise & ~ch0_rise;
   wire trig_tod  = tod_mode & tod_rise;
   wire sw_start  = ~hw_trigger_enable_in & ctrl_a_wr_in
                    & ~chan_off(ctrl_a_ch_in);
   // Writing the active control register aborts the conversion
   wire abort     = (state_reg == ST_CONV)
                    & ((ctrl_a_wr_in & ~use_b_reg)
                     | (ctrl_b_wr_in & use_b_reg));
   wire done      = (state_reg == ST_CONV) & ~abort
                    & (count_reg == CONV_CYCLES - 8'h01);
   // A continuous run stops once its channel has been switched off
   wire active_ch_off = use_b_reg ? chan_off(ch_b_reg)
                                  : chan_off(ch_a_reg);

   always @* begin
      state_next = state_reg;
      count_next = count_reg;
      use_b_next = use_b_reg;
      case (state_reg)
         ST_IDLE: begin
            // Hardware triggers only seen in idle, so busy drops them
            if (trig_a | trig_tod | sw_start) begin
               state_next = ST_CONV;
               count_next = 8'h00;
               use_b_next = 1'b0;
            end else if (trig_b) begin
               state_next = ST_CONV;
               count_next = 8'h00;
               use_b_next = 1'b1;
            end
         end
         ST_CONV: begin
            if (abort) begin
               state_next = sw_start ? ST_CONV : ST_IDLE;
               count_next = 8'h00;
            end else if (done) begin
               count_next = 8'h00;
               // Continuous repeats only under software start
               if (!continuous_in || hw_trigger_enable_in || active_ch_off)
                  state_next = ST_IDLE;
            end else begin
               count_next = count_reg + 8'h01;
            end
         end
         default: begin
            state_next = ST_IDLE;
            count_next = 8'h00;
         end
      endcase
   end

   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg                 <= ST_IDLE;
         count_reg                 <= 8'h00;
         use_b_reg                 <= 1'b0;
         ch_a_reg                  <= `ATF_CH_DISABLED;
         diff_a_reg                <= 1'b0;
         ch_b_reg                  <= `ATF_CH_DISABLED;
         diff_b_reg                <= 1'b0;
         busy_out                  <= 1'b0;
         sar_start_out             <= 1'b0;
         sar_channel_out           <= `ATF_CH_DISABLED;
         sar_diff_out              <= 1'b0;
         reference_out             <= `ATF_REF_EXT;
         select_latch_a_out        <= 1'b0;
         select_latch_b_out        <= 1'b0;
         conversion_complete_a_out <= 1'b0;
         conversion_complete_b_out <= 1'b0;
         result_a_out              <= 16'h0000;
         result_b_out              <= 16'h0000;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         use_b_reg <= use_b_next;
         busy_out  <= (state_next == ST_CONV);
         if (ctrl_a_wr_in) begin
            ch_a_reg   <= ctrl_a_ch_in;
            diff_a_reg <= ctrl_a_diff_in;
         end
         if (ctrl_b_wr_in) begin
            ch_b_reg   <= ctrl_b_ch_in;
            diff_b_reg <= ctrl_b_diff_in;
         end
         // Pulse at each start, including continuous restarts
         sar_start_out <= (state_next == ST_CONV)
                          & ((state_reg == ST_IDLE) | abort | done);
         if (state_reg == ST_IDLE || abort) begin
            sar_channel_out <= use_b_next ? ch_b_reg : 
                               (ctrl_a_wr_in ? ctrl_a_ch_in : ch_a_reg);
            sar_diff_out    <= use_b_next ? diff_b_reg :
                               (ctrl_a_wr_in ? ctrl_a_diff_in : diff_a_reg);
         end
         reference_out <= (reference_select_in == `ATF_REF_RSVD)
                          ? `ATF_REF_EXT : reference_select_in;
         // Latches are set-dominant over their clear
         if (trig_a)
            select_latch_a_out <= 1'b1;
         else if (latch_a_clr_in)
            select_latch_a_out <= 1'b0;
         if (trig_b)
            select_latch_b_out <= 1'b1;
         else if (latch_b_clr_in)
            select_latch_b_out <= 1'b0;
         // Completion beats a same-cycle clear
         if (done && !use_b_reg) begin
            conversion_complete_a_out <= 1'b1;
            result_a_out              <= fmt_data;
         end else if (ctrl_a_wr_in || result_a_lo_rd_in) begin
            conversion_complete_a_out <= 1'b0;
         end
         if (done && use_b_reg) begin
            conversion_complete_b_out <= 1'b1;
            result_b_out              <= fmt_data;
         end else if (ctrl_b_wr_in || result_b_lo_rd_in) begin
            conversion_complete_b_out <= 1'b0;
         end
      end
   end
endmodule // atf_trigger_ctrl
`default_nettype wire

/* File: atf_map.vh */
// Constants for the converter trigger and result formatting block
`ifndef ATF_MAP_VH
`define ATF_MAP_VH
`define ATF_CH_W          5
`define ATF_CH_DISABLED   5'h1F
`define ATF_REF_EXT       2'h0
`define ATF_REF_INT       2'h1
`define ATF_REF_BG        2'h2
`define ATF_REF_RSVD      2'h3
`define ATF_MODE_8_9      2'h0
`define ATF_MODE_12_13    2'h1
`define ATF_MODE_10_11    2'h2
`define ATF_MODE_16       2'h3
`define ATF_CONV_CYCLES   8'h14
`define ATF_PMODE_RUN     3'h0
`define ATF_PMODE_WAIT    3'h1
`define ATF_PMODE_LPRUN   3'h2
`define ATF_PMODE_LPWAIT  3'h3
`define ATF_PMODE_STOP3   3'h4
`endif

/* File: atf_edge_sync.v */
// Two-flop synchroniser with rising-edge pulse output
`timescale 1ns/1ps
`default_nettype none
module atf_edge_sync (
   input  wire clk_in,
   input  wire rst_b_in,
   input  wire d_in,
   output wire level_out,
   output wire rise_out
);
   reg meta_reg;
   reg sync_reg;
   reg last_reg;
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= d_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end
   assign level_out = sync_reg;
   assign rise_out  = sync_reg & ~last_reg;
endmodule // atf_edge_sync
`default_nettype wire

/* File: atf_result_fmt.v */
// Result formatter: LSB-aligned unsigned or sign-extended signed
`timescale 1ns/1ps
`default_nettype none
`include "atf_map.vh"
module atf_result_fmt (
   input  wire [15:0] raw_in,
   input  wire        diff_in,
   input  wire [1:0]  mode_in,
   output reg  [15:0] result_out
);
   // Width in bits of the chosen resolution
   function [4:0] res_bits;
      input       diff;
      input [1:0] mode;
      begin
         case (mode)
            `ATF_MODE_8_9:   res_bits = diff ? 5'h09 : 5'h08;
            `ATF_MODE_12_13: res_bits = diff ? 5'h0D : 5'h0C;
            `ATF_MODE_10_11: res_bits = diff ? 5'h0B : 5'h0A;
            default:         res_bits = 5'h10;
         endcase
      end
   endfunction
   reg [4:0]  nbits;
   reg [15:0] mask;
   reg        sign;
   always @* begin
      nbits = res_bits(diff_in, mode_in);
      mask  = (nbits == 5'h10) ? 16'hFFFF
            : ((16'h0001 << nbits[3:0]) - 16'h0001);
      sign  = raw_in[nbits[3:0] - 4'h1];
      if (diff_in)
         result_out = (raw_in & mask) | (sign ? ~mask : 16'h0000);
      else
         result_out = raw_in & mask;
   end
endmodule // atf_result_fmt
`default_nettype wire

/* File: atf_trigger_ctrl_props.sv */
// Port assertions for the converter trigger block
`timescale 1ns/1ps
`default_nettype none
`include "atf_map.vh"
module atf_trigger_ctrl_props #(parameter int CONV_CYCLES = 20) (
   input wire logic clk_in, rst_b_in, trigger_source_select_in,
   input wire logic hw_trigger_enable_in, continuous_in, timer_ch0_in,
   input wire logic tod_match_in, ctrl_a_wr_in, result_a_lo_rd_in,
   input wire logic [2:0] power_mode_in,
   input wire logic [1:0] reference_select_in, reference_out,
   input wire logic [`ATF_CH_W-1:0] ctrl_a_ch_in, sar_channel_out,
   input wire logic busy_out, sar_start_out, select_latch_a_out,
   input wire logic select_latch_b_out, conversion_complete_a_out
);
   localparam int CC_HI = CONV_CYCLES + 1;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_sw_wr;
      ctrl_a_wr_in && !hw_trigger_enable_in && !busy_out;
   endsequence
   sequence s_hw_idle;
      hw_trigger_enable_in && !busy_out;
   endsequence
   AST_SW_START: assert property (s_sw_wr ##0 ctrl_a_ch_in != `ATF_CH_DISABLED
      |=> sar_start_out && sar_channel_out == $past(ctrl_a_ch_in))
      else $error("software write did not start");
   AST_SW_OFF: assert property (s_sw_wr ##0 ctrl_a_ch_in == `ATF_CH_DISABLED
      |=> !sar_start_out && !busy_out) else $error("disabled channel started");
   AST_REF: assert property (reference_out == (($past(reference_select_in)
      == 2'h3) ? 2'h0 : $past(reference_select_in))) else $error("bad reference");
   AST_BUSY_DROP: assert property (busy_out && hw_trigger_enable_in
      |=> !sar_start_out) else $error("trigger taken while busy");
   AST_DONE: assert property (sar_start_out && !continuous_in
      |-> busy_out [*3] ##[1:CC_HI] !busy_out) else $error("no return to idle");
   AST_FLAG_CLR: assert property ((ctrl_a_wr_in || result_a_lo_rd_in)
      && !busy_out |=> !conversion_complete_a_out) else $error("flag not cleared");
   AST_TOD: assert property (s_hw_idle ##0 (!trigger_source_select_in
      && $rose(tod_match_in)) |-> ##[1:5] sar_start_out) else $error("match lost");
   AST_LATCH: assert property (s_hw_idle ##0 (trigger_source_select_in
      && power_mode_in != 3'h4 && $rose(timer_ch0_in)) |-> ##[1:5]
      select_latch_a_out) else $error("latch a not set");
   AST_STOP: assert property ((power_mode_in == 3'h4 || !hw_trigger_enable_in)
      [*6] |=> !$rose(select_latch_a_out) && !$rose(select_latch_b_out))
      else $error("timer edge acted when it must not");
endmodule // atf_trigger_ctrl_props
bind atf_trigger_ctrl atf_trigger_ctrl_props #(.CONV_CYCLES(CONV_CYCLES)) props_u (
   .clk_in, .rst_b_in, .trigger_source_select_in, .hw_trigger_enable_in,
   .continuous_in, .timer_ch0_in, .tod_match_in, .ctrl_a_wr_in,
   .result_a_lo_rd_in, .power_mode_in, .reference_select_in, .reference_out,
   .ctrl_a_ch_in, .sar_channel_out, .busy_out, .sar_start_out,
   .select_latch_a_out, .select_latch_b_out, .conversion_complete_a_out);
`default_nettype wire

/* File: atf_timer_tod_model.sv */
// Timer channel and time-of-day match model facing the trigger block
`timescale 1ns/1ps
`default_nettype none
module atf_timer_tod_model (
   input  wire logic clk_in,
   output var  logic ch0_out,
   output var  logic ch1_out,
   output var  logic tod_out
);
   initial {ch0_out, ch1_out, tod_out} = 3'h0;
   // Only one source per pulse, so both channels never rise together
   task automatic pulse(input int which, input int hi);
      @(posedge clk_in);
      #1;
      ch0_out = (which == 0);
      ch1_out = (which == 1);
      tod_out = (which == 2);
      repeat (hi) @(posedge clk_in);
      #1;
      {ch0_out, ch1_out, tod_out} = 3'h0;
   endtask
endmodule // atf_timer_tod_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the converter trigger block
`timescale 1ns/1ps
`default_nettype none
`define CMP(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
   $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module testbench;
   logic clk_in = 0, rst_b_in = 0, tss = 0, hw_en = 0, cont = 0, pa = 0, pb = 0;
   logic a_wr = 0, b_wr = 0, a_diff = 0, b_diff = 0, a_rd = 0, b_rd = 0;
   logic la_clr = 0, lb_clr = 0;
   logic [2:0] pmode = 0;
   logic [1:0] rsel = 0, rmode = 0, rout;
   logic [4:0] a_ch = 0, b_ch = 0, sch;
   logic [15:0] raw = 0, ra, rb;
   logic ch0, ch1, tod, busy, start, sdiff, la, lb, ca, cb;
   int fails = 0, samples_checked = 0, seed = 32'h6a758783;
   logic [15:0] q[$];
   logic [15:0] exp_v;
   initial forever #5 clk_in = ~clk_in;
   atf_timer_tod_model tm_u (.clk_in(clk_in), .ch0_out(ch0), .ch1_out(ch1),
      .tod_out(tod));
   atf_trigger_ctrl #(.CONV_CYCLES(8'h0C)) dut_u (.clk_in(clk_in),
      .rst_b_in(rst_b_in), .trigger_source_select_in(tss),
      .hw_trigger_enable_in(hw_en), .continuous_in(cont), .power_mode_in(pmode),
      .reference_select_in(rsel), .timer_ch0_in(ch0), .timer_ch1_in(ch1),
      .tod_match_in(tod), .ctrl_a_wr_in(a_wr), .ctrl_a_ch_in(a_ch),
      .ctrl_a_diff_in(a_diff), .ctrl_b_wr_in(b_wr), .ctrl_b_ch_in(b_ch),
      .ctrl_b_diff_in(b_diff), .res_mode_in(rmode), .result_a_lo_rd_in(a_rd),
      .result_b_lo_rd_in(b_rd), .sar_data_in(raw), .latch_a_clr_in(la_clr),
      .latch_b_clr_in(lb_clr), .busy_out(busy), .sar_start_out(start),
      .sar_channel_out(sch), .sar_diff_out(sdiff), .reference_out(rout),
      .select_latch_a_out(la), .select_latch_b_out(lb),
      .conversion_complete_a_out(ca), .conversion_complete_b_out(cb),
      .result_a_out(ra), .result_b_out(rb));
   // Result scoreboard: one note per expected completion
   always @(posedge clk_in) begin
      if (ca === 1'b1 && !pa) begin
         exp_v = q.size() ? q.pop_front() : 16'hXXXX;
         `CMP(ra, exp_v)
      end
      if (cb === 1'b1 && !pb) begin
         exp_v = q.size() ? q.pop_front() : 16'hXXXX;
         `CMP(rb, exp_v)
      end
      pa <= ca;
      pb <= cb;
   end
   function automatic logic [15:0] fmt(logic [15:0] r, logic d, logic [1:0] m);
      int n;
      logic [16:0] mk;
      n = (m == 2'h3) ? 16 : (m == 2'h1) ? 12 : (m == 2'h2) ? 10 : 8;
      if (d && m != 2'h3) n = n + 1;
      mk = (17'h1 << n) - 17'h1;
      fmt = r & mk[15:0];
      if (d && r[n-1]) fmt = fmt | ~mk[15:0];
   endfunction
   task automatic tick(int n = 1);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic finish_conv();
      int i;
      for (i = 0; i < 40 && busy !== 1'b0; i++) tick();
      `CMP(busy, 1'b0)
      {a_rd, b_rd, la_clr, lb_clr} = 4'hF;
      tick();
      {a_rd, b_rd, la_clr, lb_clr} = 4'h0;
      `CMP(ca | cb, 1'b0)
   endtask
   task automatic conv_sw(logic d, logic [1:0] m);
      a_diff = d;
      rmode = m;
      raw = $random(seed);
      a_ch = 5'($unsigned($random(seed)) % 31);
      q.push_back(fmt(raw, d, m));
      a_wr = 1;
      tick();
      a_wr = 0;
      `CMP(start, 1'b1)
      `CMP(sch, a_ch)
      `CMP(sdiff, d)
      finish_conv();
   endtask
   task automatic conv_hw(int w, logic d, logic [1:0] m, bit twice);
      int i;
      raw = $random(seed);
      rmode = m;
      q.push_back(fmt(raw, d, m));
      tm_u.pulse(w, 2);
      for (i = 0; i < 8 && busy !== 1'b1; i++) tick();
      `CMP(busy, 1'b1)
      if (w < 2) `CMP(w ? lb : la, 1'b1)
      `CMP(sch, (w == 1) ? 5'h03 : 5'h05)
      `CMP(sdiff, d)
      if (twice) tm_u.pulse(w, 1);
      finish_conv();
      tick(6);
      `CMP(busy, 1'b0)
   endtask
   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge clk_in);
      #1;
      rst_b_in = 1;
      tick(2);
      for (int i = 0; i < 8; i++) conv_sw(i[2], i[1:0]);
      $display("test formats done");
      a_ch = 5'h1F;
      a_wr = 1;
      tick();
      a_wr = 0;
      tick();
      `CMP(busy, 1'b0)
      for (int r = 0; r < 4; r++) begin
         rsel = r[1:0];
         tick(2);
         `CMP(rout, (r == 3) ? 2'h0 : r[1:0])
      end
      $display("test reference done");
      cont = 1;
      raw = $random(seed);
      q.push_back(fmt(raw, a_diff, rmode));
      a_ch = 5'h07;
      a_wr = 1;
      tick();
      a_wr = 0;
      tick(14);
      `CMP(busy, 1'b1)
      a_ch = 5'h1F;
      a_wr = 1;
      tick();
      a_wr = 0;
      cont = 0;
      finish_conv();
      $display("test continuous done");
      hw_en = 1;
      {a_diff, b_diff, a_ch, b_ch} = {2'b01, 5'h05, 5'h03};
      {a_wr, b_wr} = 2'b11;
      tick();
      {a_wr, b_wr} = 2'b00;
      for (int p = 0; p < 5; p++) begin
         pmode = p[2:0];
         conv_hw(2, 1'b0, p[1:0], p == 0);
      end
      pmode = 0;
      tss = 1;
      conv_hw(0, 1'b0, 2'h3, 1'b0);
      conv_hw(1, 1'b1, 2'h0, 1'b1);
      $display("test hardware triggers done");
      for (int k = 0; k < 2; k++) begin
         {hw_en, pmode} = k ? 4'h0 : 4'hC;
         tm_u.pulse(0, 2);
         tm_u.pulse(1, 2);
         tick(6);
         `CMP({la, lb, busy}, 3'h0)
      end
      $display("test ignored edges done");
      summarize();
   end
endmodule // testbench
`default_nettype wire
